/* File: parport_gpio_regs.vh */
// register offsets, field positions, reset values and timing counts of the parallel port block
// *****************************************************************
// What this block does
// (RQ1) seventeen pins: eight data, four control, five status
// (RQ2) output data mode: twelve outputs, five inputs
// (RQ3) input data mode: four outputs, thirteen inputs
// (RQ4) extended mode: eight outputs, nine inputs
// (RQ5) direction locks once; unknown combinations refused
// (RQ6) up to eight ports, numbered from zero
// (RQ7) address value below sixteen means port index
// (RQ8) default output; no configured port flags error
// (RQ9) pins two to nine form data group
// (RQ10) pins 1, 14, 16, 17 driven in output and input modes, open-collector in extended mode
// (RQ11) extended mode also samples control pins
// (RQ12) pins 10 to 13 and 15 input always
// (RQ13) each input gives true and inverted copies
// (RQ14) per-pin output invert setting
// (RQ15) per-pin enable for reset strobe
// (RQ16) per-port reset delay in nanoseconds
// (RQ17) reset waits delay, then drives invert level
// (RQ18) caller issues reset after write, same cycle
// (RQ19) read strobe samples inputs, per port or all
// (RQ20) write strobe drives inverted outputs to pins
// (RQ21) caller sets step spacing zero for double-step
// (RQ22) external control drivers should be open-collector
// (RQ23) outputs hold; delay counted in clock cycles
// *****************************************************************
`ifndef PARPORT_GPIO_REGS_VH
`define PARPORT_GPIO_REGS_VH

// per-port window, selected by address bits 7:5
`define REG_CFG        3'h0
`define REG_ADDR       3'h1
`define REG_OUT        3'h2
`define REG_INV        3'h3
`define REG_RSTEN      3'h4
`define REG_RTIME      3'h5
`define REG_IN         3'h6
`define REG_INN        3'h7
// global registers, address bit 8 set
`define REG_CMD        3'h0
`define REG_STATUS     3'h1

`define CFG_MODE_LSB   0
`define CFG_EN_BIT     2
`define CFG_LOCK_BIT   3
`define CFG_IDX_BIT    4

`define MODE_OUT       2'h0
`define MODE_IN        2'h1
`define MODE_EXT       2'h2
`define MODE_BAD       2'h3

`define CMD_RD_LSB     0
`define CMD_WR_LSB     8
`define CMD_RS_LSB     16
`define ST_NOPORT_BIT  0
`define ST_BADMODE_BIT 1
`define ST_LOCK_LSB    8

`define INDEX_LIMIT    16'h0010
`define RST_RTIME      32'h0000_0000
`define RST_PIN        17'h0_0000

// pin bit n is connector pin n+1
`define DATA_MASK      17'h0_01fe
`define CTRL_MASK      17'h1_a001
`define STAT_MASK      17'h0_5e00

`define CLK_PERIOD_NS  32'd10

`endif

/* File: port_pins.v */
// pin logic of one parallel port: direction, inversion, input sampling, timed reset
`timescale 1ns/1ns
`include "parport_gpio_regs.vh"

module port_pins (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire [1:0]  mode_in,
    input  wire        en_in,
    input  wire [16:0] out_val_in,
    input  wire [16:0] inv_in,
    input  wire [16:0] rsten_in,
    input  wire [31:0] rtime_in,
    input  wire        rd_stb_in,
    input  wire        wr_stb_in,
    input  wire        rs_stb_in,
    input  wire [16:0] pin_in,
    output reg  [16:0] pin_out,      // [RQ1]
    output reg  [16:0] pin_oe_out,
    output reg  [16:0] in_true_out,
    output reg  [16:0] in_not_out
);

    // *****************************************************************
    // direction masks
    // *****************************************************************
    wire        is_out = (mode_in == `MODE_OUT);
    wire        is_in  = (mode_in == `MODE_IN);
    wire        is_ext = (mode_in == `MODE_EXT);
    wire [16:0] out_mask = `CTRL_MASK | (is_in ? 17'h0_0000 : `DATA_MASK); // [RQ2] [RQ3] [RQ4] [RQ9] [RQ10]
    wire [16:0] in_mask  = `STAT_MASK | (is_in ? `DATA_MASK : 17'h0_0000)  // [RQ12] [RQ9]
                         | (is_ext ? `CTRL_MASK : 17'h0_0000);             // [RQ11]

    // round the delay up to whole clock cycles
    wire [32:0] rt_sum   = {1'b0, rtime_in} + {1'b0, `CLK_PERIOD_NS} - 33'd1;
    wire [32:0] rt_cyc33 = rt_sum / {1'b0, `CLK_PERIOD_NS};
    wire [31:0] rt_cyc   = rt_cyc33[31:0];

    reg  [16:0] lvl_ff;
    reg  [31:0] cnt_ff;
    reg         pend_ff;
    reg  [16:0] nxt_lvl;
    reg  [31:0] nxt_cnt;
    reg         nxt_pend;
    reg         do_reset;

    // *****************************************************************
    // write and timed reset
    // *****************************************************************
    always @* begin
        nxt_lvl  = lvl_ff;
        nxt_cnt  = cnt_ff;
        nxt_pend = pend_ff | rs_stb_in;
        do_reset = 1'b0;
        if (cnt_ff != 32'd0) begin
            nxt_cnt = cnt_ff - 32'd1;                           // [RQ23]
        end
        if (wr_stb_in) begin
            nxt_lvl  = (out_val_in ^ inv_in) & out_mask;        // [RQ14] [RQ20]
            nxt_cnt  = rt_cyc;                                  // [RQ16] [RQ23]
            nxt_pend = rs_stb_in;                               // [RQ18]
        end else if (nxt_pend && cnt_ff == 32'd0) begin
            do_reset = 1'b1;                                    // [RQ17]
            nxt_pend = 1'b0;
        end
        if (do_reset) begin
            nxt_lvl = (lvl_ff & ~rsten_in) | (inv_in & rsten_in & out_mask); // [RQ15] [RQ17]
        end
    end

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lvl_ff      <= `RST_PIN;
            cnt_ff      <= 32'd0;
            pend_ff     <= 1'b0;
            pin_out     <= `RST_PIN;
            pin_oe_out  <= `RST_PIN;
            in_true_out <= `RST_PIN;
            in_not_out  <= `RST_PIN;
        end else begin
            lvl_ff  <= nxt_lvl;                                 // [RQ23]
            cnt_ff  <= nxt_cnt;
            pend_ff <= nxt_pend;
            pin_out <= lvl_ff & out_mask;
            // extended mode drives control pins open-collector: release when high
            if (!en_in) begin
                pin_oe_out <= `RST_PIN;
            end else if (is_ext) begin
                pin_oe_out <= `DATA_MASK | (`CTRL_MASK & ~lvl_ff); // [RQ4] [RQ11]
            end else begin
                pin_oe_out <= out_mask & {17{is_out | is_in}};  // [RQ10]
            end
            if (rd_stb_in) begin
                in_true_out <= pin_in & in_mask;                // [RQ13] [RQ19]
                in_not_out  <= ~pin_in & in_mask;               // [RQ13] [RQ19]
            end
        end
    end

endmodule

/* File: parport_gpio.v */
// parallel port pin block: Avalon-MM register slave and up to eight port instances
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "parport_gpio_regs.vh"

module parport_gpio #(
    parameter NUM_PORTS = 8
) (
    input  wire                    mclk_in,
    input  wire                    rst_n_in,
    input  wire [8:0]              address_in,
    input  wire                    read_in,
    input  wire                    write_in,
    input  wire [31:0]             writedata_in,
    output reg  [31:0]             readdata_out,
    output reg                     waitrequest_out,
    input  wire [17*NUM_PORTS-1:0] pin_in,
    output wire [17*NUM_PORTS-1:0] pin_out,
    output wire [17*NUM_PORTS-1:0] pin_oe_out
);

    // *****************************************************************
    // reset release
    // *****************************************************************
    reg rst_meta_ff;
    reg rst_sync_ff;

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire rst_n = rst_sync_ff;

    // *****************************************************************
    // bus decode
    // *****************************************************************
    // one wait state on every access: the request is answered one edge after
    // it is seen, and a write takes effect on the edge with waitrequest low
    wire       wr_hit   = write_in & ~waitrequest_out;
    wire       is_glb   = address_in[8];
    wire [2:0] port_sel = address_in[7:5];
    wire [2:0] reg_sel  = address_in[4:2];

    wire cmd_wr  = wr_hit && is_glb && reg_sel == `REG_CMD;
    wire stat_wr = wr_hit && is_glb && reg_sel == `REG_STATUS;

    wire [NUM_PORTS-1:0] rd_stb = cmd_wr ? writedata_in[`CMD_RD_LSB +: NUM_PORTS]
                                         : {NUM_PORTS{1'b0}}; // [RQ19]
    wire [NUM_PORTS-1:0] wr_stb = cmd_wr ? writedata_in[`CMD_WR_LSB +: NUM_PORTS]
                                         : {NUM_PORTS{1'b0}}; // [RQ20]
    wire [NUM_PORTS-1:0] rs_stb = cmd_wr ? writedata_in[`CMD_RS_LSB +: NUM_PORTS]
                                         : {NUM_PORTS{1'b0}}; // [RQ18]

    // *****************************************************************
    // per-port registers and pin logic
    // *****************************************************************
    wire [NUM_PORTS-1:0]    en_vec;
    wire [NUM_PORTS-1:0]    lock_vec;
    wire [NUM_PORTS-1:0]    bad_vec;
    wire [32*NUM_PORTS-1:0] cfg_rd;
    wire [32*NUM_PORTS-1:0] addr_rd;
    wire [17*NUM_PORTS-1:0] out_rd;
    wire [17*NUM_PORTS-1:0] inv_rd;
    wire [17*NUM_PORTS-1:0] rsten_rd;
    wire [32*NUM_PORTS-1:0] rtime_rd;
    wire [17*NUM_PORTS-1:0] in_true;
    wire [17*NUM_PORTS-1:0] in_not;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port // [RQ6]
            reg  [1:0]  mode_ff;
            reg         en_ff;
            reg         lock_ff;
            reg  [15:0] addr_ff;
            reg  [16:0] out_ff;
            reg  [16:0] inv_ff;
            reg  [16:0] rsten_ff;
            reg  [31:0] rtime_ff;
            // a genvar cannot be part-selected, so the index gets a sized copy
            localparam [2:0] PIDX = p;
            wire        sel = wr_hit && !is_glb && port_sel == PIDX;
            wire        cfg_wr = sel && reg_sel == `REG_CFG;
            wire [1:0]  req_mode = writedata_in[`CFG_MODE_LSB +: 2];

            assign bad_vec[p] = cfg_wr && !lock_ff && req_mode == `MODE_BAD; // [RQ5]

            always @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    mode_ff  <= `MODE_OUT;                      // [RQ8]
                    en_ff    <= 1'b0;
                    lock_ff  <= 1'b0;
                    addr_ff  <= 16'h0000;
                    out_ff   <= `RST_PIN;
                    inv_ff   <= `RST_PIN;
                    rsten_ff <= `RST_PIN;
                    rtime_ff <= `RST_RTIME;
                end else begin
                    // direction follows each unlocked write of a known mode and locks on the write that enables the port
                    if (cfg_wr && !lock_ff && req_mode != `MODE_BAD) begin // [RQ5]
                        mode_ff <= req_mode;
                        en_ff   <= writedata_in[`CFG_EN_BIT];
                        lock_ff <= writedata_in[`CFG_EN_BIT];
                    end
                    if (sel && reg_sel == `REG_ADDR && !lock_ff) begin
                        addr_ff <= writedata_in[15:0];
                    end
                    if (sel && reg_sel == `REG_OUT) begin
                        out_ff <= writedata_in[16:0];
                    end
                    if (sel && reg_sel == `REG_INV) begin
                        inv_ff <= writedata_in[16:0];           // [RQ14]
                    end
                    if (sel && reg_sel == `REG_RSTEN) begin
                        rsten_ff <= writedata_in[16:0];         // [RQ15]
                    end
                    if (sel && reg_sel == `REG_RTIME) begin
                        rtime_ff <= writedata_in;               // [RQ16]
                    end
                end
            end

            assign en_vec[p]           = en_ff;
            assign lock_vec[p]         = lock_ff;
            assign cfg_rd[32*p +: 32]  = {27'h000_0000,
                                          addr_ff < `INDEX_LIMIT, // [RQ7]
                                          lock_ff, en_ff, mode_ff};
            assign addr_rd[32*p +: 32] = {16'h0000, addr_ff};
            assign out_rd[17*p +: 17]  = out_ff;
            assign inv_rd[17*p +: 17]  = inv_ff;
            assign rsten_rd[17*p +: 17] = rsten_ff;
            assign rtime_rd[32*p +: 32] = rtime_ff;

            port_pins u_pins (
                .mclk_in     (mclk_in),
                .rst_n_in    (rst_n),
                .mode_in     (mode_ff),
                .en_in       (en_ff),
                .out_val_in  (out_ff),
                .inv_in      (inv_ff),
                .rsten_in    (rsten_ff),
                .rtime_in    (rtime_ff),
                .rd_stb_in   (rd_stb[p]),
                .wr_stb_in   (wr_stb[p] & en_ff),
                .rs_stb_in   (rs_stb[p] & en_ff),
                .pin_in      (pin_in[17*p +: 17]),
                .pin_out     (pin_out[17*p +: 17]),
                .pin_oe_out  (pin_oe_out[17*p +: 17]),
                .in_true_out (in_true[17*p +: 17]),
                .in_not_out  (in_not[17*p +: 17])
            );
        end
    endgenerate

    // *****************************************************************
    // global status
    // *****************************************************************
    reg bad_mode_ff;

    // a refused mode in the clearing cycle still sets the flag
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            bad_mode_ff <= 1'b0;
        end else if (|bad_vec) begin
            bad_mode_ff <= 1'b1;                                // [RQ5]
        end else if (stat_wr && writedata_in[`ST_BADMODE_BIT]) begin
            bad_mode_ff <= 1'b0;
        end
    end

    wire [31:0] status_word = {{(24-NUM_PORTS){1'b0}}, lock_vec,
                               6'h00, bad_mode_ff, ~(|en_vec)}; // [RQ8]

    // *****************************************************************
    // read mux and bus handshake
    // *****************************************************************
    wire        port_ok = {1'b0, port_sel} < NUM_PORTS;
    reg  [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (is_glb) begin
            if (reg_sel == `REG_STATUS) begin
                nxt_rdata = status_word;
            end
        end else if (port_ok) begin
            case (reg_sel)
                `REG_CFG:   nxt_rdata = cfg_rd[32*port_sel +: 32];
                `REG_ADDR:  nxt_rdata = addr_rd[32*port_sel +: 32];
                `REG_OUT:   nxt_rdata = {15'h0000, out_rd[17*port_sel +: 17]};
                `REG_INV:   nxt_rdata = {15'h0000, inv_rd[17*port_sel +: 17]};
                `REG_RSTEN: nxt_rdata = {15'h0000, rsten_rd[17*port_sel +: 17]};
                `REG_RTIME: nxt_rdata = rtime_rd[32*port_sel +: 32];
                `REG_IN:    nxt_rdata = {15'h0000, in_true[17*port_sel +: 17]}; // [RQ13]
                default:    nxt_rdata = {15'h0000, in_not[17*port_sel +: 17]};  // [RQ13]
            endcase
        end
    end

    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest_out <= 1'b1;
            readdata_out    <= 32'h0000_0000;
        end else if ((read_in || write_in) && waitrequest_out) begin
            waitrequest_out <= 1'b0;
            readdata_out    <= read_in ? nxt_rdata : 32'h0000_0000;
        end else begin
            waitrequest_out <= 1'b1;
        end
    end

endmodule

/* File: parport_gpio_props.sv */
// assertion checker watching the ports of the parallel port block
`timescale 1ns/1ns
`include "parport_gpio_regs.vh"
module parport_gpio_chk #(
    parameter NUM_PORTS = 8
) (
    input wire                    mclk_in,
    input wire                    rst_n_in,
    input wire [8:0]              address_in,
    input wire                    read_in,
    input wire                    write_in,
    input wire [31:0]             writedata_in,
    input wire [31:0]             readdata_out,
    input wire                    waitrequest_out,
    input wire [17*NUM_PORTS-1:0] pin_in,
    input wire [17*NUM_PORTS-1:0] pin_out,
    input wire [17*NUM_PORTS-1:0] pin_oe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ********
    // bus handshake
    // ********
    sequence s_answer;
        (read_in || write_in) && !waitrequest_out;
    endsequence
    sequence s_local_read;
        read_in && !address_in[8];
    endsequence
    AST_ONE_WAIT: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("answer held longer than one cycle");
    AST_ANSWER: assert property ((read_in || write_in) |-> ##[0:2] !waitrequest_out)
        else $error("request not answered in time");
    AST_IDLE: assert property (!read_in && !write_in |=> waitrequest_out)
        else $error("answer without request");
    // outputs still quiet while the reset synchroniser drains
    AST_RESET_EXIT: assert property ($rose(rst_n_in) |-> waitrequest_out && pin_oe_out == '0)
        else $error("outputs active at reset exit");
    AST_UNMAPPED: assert property (s_answer ##0 s_local_read ##0 (address_in[7:5] >= NUM_PORTS)
        |-> readdata_out == 32'h0)
        else $error("absent port read not zero");
    AST_IN_UPPER: assert property (s_answer ##0 s_local_read ##0 (address_in[4:3] == 2'h3)
        |-> readdata_out[31:17] == 15'h0)
        else $error("input copy upper bits set");
    // ********
    // pin groups
    // ********
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g = g + 1) begin : per_port
            AST_STATUS_IN: assert property ((pin_oe_out[17*g+:17] & `STAT_MASK) == 17'h0)
                else $error("status pin driven");
            AST_STATUS_LOW: assert property ((pin_out[17*g+:17] & `STAT_MASK) == 17'h0)
                else $error("status pin level set");
            AST_DATA_GROUP: assert property ((pin_oe_out[17*g+:17] & `DATA_MASK) == 17'h0 ||
                (pin_oe_out[17*g+:17] & `DATA_MASK) == `DATA_MASK)
                else $error("data group split");
        end
    endgenerate
endmodule
bind parport_gpio parport_gpio_chk #(
    .NUM_PORTS(NUM_PORTS)
) u_parport_gpio_chk (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .writedata_in(writedata_in),
    .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out)
);

/* File: port_far_side.sv */
// far-side wiring model: external drivers and open-collector sinks on the connector
`timescale 1ns/1ns
module port_far_side #(
    parameter NP = 3
) (
    input  wire [17*NP-1:0] drv_in,
    input  wire [17*NP-1:0] oe_in,
    input  wire [17*NP-1:0] ext_in,
    input  wire [17*NP-1:0] sink_in,
    output wire [17*NP-1:0] lvl_out
);
    // ********
    // wire level
    // ********
    // sinks only pull low, so a released control pin never fights the block
    assign lvl_out = ((oe_in & drv_in) | (~oe_in & ext_in)) & ~sink_in;
endmodule

/* File: test_parport_gpio.sv */
// self-checking testbench of the parallel port block
`timescale 1ns/1ns
`include "parport_gpio_regs.vh"
module test_parport_gpio;
    localparam NP = 3;
    localparam [16:0] OUTM = `DATA_MASK | `CTRL_MASK;
    localparam [16:0] IN1 = `DATA_MASK | `STAT_MASK;
    localparam [16:0] IN2 = `CTRL_MASK | `STAT_MASK;
    localparam [16:0] LVL0 = (17'h1_5055 ^ 17'h0_00f0) & OUTM;
    reg              mclk_in;
    reg              rst_n_in;
    reg  [8:0]       address_in;
    reg              read_in;
    reg              write_in;
    reg  [31:0]      writedata_in;
    wire [31:0]      readdata_out;
    wire             waitrequest_out;
    wire [17*NP-1:0] pin_in;
    wire [17*NP-1:0] pin_out;
    wire [17*NP-1:0] pin_oe_out;
    reg  [17*NP-1:0] ext_lvl;
    reg  [17*NP-1:0] sink;
    reg  [31:0]      rd;
    integer          fails;
    integer          compares;
    parport_gpio #(
        .NUM_PORTS(NP)
    ) u_parport_gpio (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .address_in(address_in),
        .read_in(read_in),
        .write_in(write_in),
        .writedata_in(writedata_in),
        .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe_out(pin_oe_out)
    );
    port_far_side #(
        .NP(NP)
    ) u_port_far_side (
        .drv_in(pin_out),
        .oe_in(pin_oe_out),
        .ext_in(ext_lvl),
        .sink_in(sink),
        .lvl_out(pin_in)
    );
    always #5 mclk_in = ~mclk_in;
    // ********
    // helpers
    // ********
    task print_verdict;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task chk_word(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task chk_pins(input [16:0] got, input [16:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    function [8:0] ra(input [2:0] p, input [2:0] r);
        ra = {1'b0, p, r, 2'b00};
    endfunction
    // holds the request until waitrequest is seen low, then releases it
    task bus(input wr, input [8:0] a, input [31:0] d);
        integer n;
        begin
            read_in <= ~wr;
            write_in <= wr;
            address_in <= a;
            writedata_in <= d;
            n = 0;
            @(posedge mclk_in);
            while (waitrequest_out !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    fails = fails + 1;
                    print_verdict;
                end
                @(posedge mclk_in);
            end
            rd = readdata_out;
            read_in <= 1'b0;
            write_in <= 1'b0;
            @(posedge mclk_in);
        end
    endtask
    // ********
    // scenarios
    // ********
    task sc_reset;
        begin
            chk_pins(pin_oe_out[16:0], 17'h0);
            bus(1'b0, 9'h104, 32'h0);
            chk_word(rd, 32'h1);
            bus(1'b0, ra(0, `REG_CFG), 32'h0);
            chk_word(rd, 32'h10);
            bus(1'b0, ra(0, `REG_RTIME), 32'h0);
            chk_word(rd, `RST_RTIME);
        end
    endtask
    task sc_config;
        begin
            bus(1'b1, ra(0, `REG_ADDR), 32'h3);
            bus(1'b1, ra(0, `REG_CFG), 32'h4);
            bus(1'b1, ra(0, `REG_CFG), 32'h5);
            bus(1'b0, ra(0, `REG_CFG), 32'h0);
            chk_word(rd, 32'h1c);
            bus(1'b1, ra(1, `REG_ADDR), 32'h378);
            bus(1'b1, ra(1, `REG_CFG), 32'h7);
            bus(1'b0, 9'h104, 32'h0);
            chk_word(rd, 32'h102);
            bus(1'b1, 9'h104, 32'h2);
            bus(1'b0, 9'h104, 32'h0);
            chk_word(rd, 32'h100);
            bus(1'b1, ra(1, `REG_CFG), 32'h5);
            bus(1'b0, ra(1, `REG_CFG), 32'h0);
            chk_word(rd, 32'h0d);
            bus(1'b1, ra(2, `REG_ADDR), 32'h2);
            bus(1'b1, ra(2, `REG_CFG), 32'h6);
            bus(1'b0, ra(2, `REG_CFG), 32'h0);
            chk_word(rd, 32'h1e);
            chk_pins(pin_oe_out[16:0], OUTM);
            chk_pins(pin_oe_out[33:17], `CTRL_MASK);
        end
    endtask
    task sc_write;
        begin
            bus(1'b1, ra(0, `REG_OUT), 32'h1_5055);
            bus(1'b1, ra(0, `REG_INV), 32'hf0);
            bus(1'b1, 9'h100, 32'h100);
            repeat (4) @(posedge mclk_in);
            chk_pins(pin_out[16:0], LVL0);
        end
    endtask
    task sc_read;
        begin
            ext_lvl[33:17] <= 17'h0_a5a5;
            bus(1'b1, 9'h100, 32'hff);
            bus(1'b0, ra(1, `REG_IN), 32'h0);
            chk_word(rd, {15'h0, 17'h0_a5a5 & IN1});
            bus(1'b0, ra(1, `REG_INN), 32'h0);
            chk_word(rd, {15'h0, ~17'h0_a5a5 & IN1});
            ext_lvl[50:34] <= 17'h1_ffff;
            sink[34] <= 1'b1;
            bus(1'b1, ra(2, `REG_OUT), {15'h0, OUTM});
            bus(1'b1, 9'h100, 32'h400);
            repeat (4) @(posedge mclk_in);
            chk_pins(pin_oe_out[50:34], `DATA_MASK);
            bus(1'b1, 9'h100, 32'h4);
            bus(1'b0, ra(2, `REG_IN), 32'h0);
            chk_word(rd, {15'h0, 17'h1_fffe & IN2});
        end
    endtask
    task sc_double;
        begin
            bus(1'b1, ra(0, `REG_RSTEN), 32'h3c);
            bus(1'b1, ra(0, `REG_RTIME), 32'h64);
            bus(1'b1, 9'h100, 32'h0001_0100);
            repeat (4) @(posedge mclk_in);
            chk_pins(pin_out[16:0], LVL0);
            repeat (16) @(posedge mclk_in);
            chk_pins(pin_out[16:0], (LVL0 & ~17'h3c) | (17'h0_00f0 & 17'h3c));
        end
    endtask
    task sc_unmapped;
        begin
            bus(1'b1, ra(5, `REG_OUT), 32'hffff);
            bus(1'b0, ra(5, `REG_OUT), 32'h0);
            chk_word(rd, 32'h0);
            bus(1'b0, 9'h108, 32'h0);
            chk_word(rd, 32'h0);
        end
    endtask
    initial begin
        mclk_in = 1'b0;
        rst_n_in = 1'b0;
        address_in = 9'h0;
        read_in = 1'b0;
        write_in = 1'b0;
        writedata_in = 32'h0;
        ext_lvl = '0;
        sink = '0;
        fails = 0;
        compares = 0;
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        sc_reset;
        sc_config;
        sc_write;
        sc_read;
        sc_double;
        sc_unmapped;
        print_verdict;
    end
endmodule
